// ### hw/ccf_defines.vh
// constants for the clock start-up and failover controller
// assumes a 10 MHz REF_CLK and a 32-bit AXI4-Lite register port
//
// What this block does
// - reset or low-power exit runs from RC
// - crystal enabled at once, stabilisation counted
// - crystal loss falls back to RC, interrupt
// - flash fetch: AHB max 60, APB 32 MHz
// - SRAM fetch: AHB max 64 MHz
// - slow mode divides AHB clock further down
// - USB 48 MHz taken from main PLL
// - AHB, USB, APB dividers chosen independently
// - burst flash: 0 sequential, 1 random wait
// - no burst: zero waits, max 32 MHz
// - boot pins sampled at start-up
// - slow low-power: PLL, crystal off, LP clock
`ifndef CCF_DEFINES_VH
`define CCF_DEFINES_VH
// ==========================================================
// register byte offsets
`define CCF_REG_CTRL      8'h00
`define CCF_REG_DIV       8'h04
`define CCF_REG_STAT      8'h08
`define CCF_REG_IRQ_STAT  8'h0C
`define CCF_REG_IRQ_MASK  8'h10
// ==========================================================
// control register bits
`define CCF_CTRL_PLL_SEL  0
`define CCF_CTRL_XT8      1
`define CCF_CTRL_SRAM     2
`define CCF_CTRL_BURST    3
`define CCF_CTRL_SLOW     4
`define CCF_CTRL_SLOW_LP  5
`define CCF_CTRL_RST      32'h0000_0000
// divider register: mul[5:0], ahb[11:8], apb[15:12], usb[19:16], slow[23:20]
`define CCF_DIV_RST       32'h0000_0000
// interrupt bits
`define CCF_IRQ_FAIL      0
`define CCF_IRQ_READY     1
`define CCF_IRQ_REJECT    2
// ==========================================================
// source codes
`define CCF_SRC_RC        2'h0
`define CCF_SRC_XT        2'h1
`define CCF_SRC_PLL       2'h2
`define CCF_SRC_LP        2'h3
// ==========================================================
// frequency limits in kHz
`define CCF_AHB_FLASH_KHZ 17'h0EA60
`define CCF_AHB_SRAM_KHZ  17'h0FA00
`define CCF_APB_MAX_KHZ   17'h07D00
`define CCF_NOBURST_KHZ   17'h07D00
`define CCF_USB_KHZ       17'h0BB80
// ==========================================================
// timing
`define CCF_CLK_NS        100
`define CCF_LOSS_NS       2000
`define CCF_LOSS_CYC      ((`CCF_LOSS_NS + `CCF_CLK_NS - 1) / `CCF_CLK_NS)
`define CCF_BOOT_CYC      4
`endif

// ### hw/ccf_clock_ctrl.v
// clock start-up, crystal supervision, source switching and clock tree config
// assumes all clock inputs are slow relative to REF_CLK and pass synchronisers
`timescale 1ns/10ps
`include "ccf_defines.vh"
module ccf_clock_ctrl #(
    parameter STAB_EDGES = 2048
) (
    input  wire        REF_CLK,
    input  wire        RST_N,
    input  wire        LP_EXIT,
    input  wire        RC_CLK_IN,
    input  wire        XTAL_CLK_IN,
    input  wire        LP_CLK_IN,
    input  wire        PLL_CLK_IN,
    input  wire        PLL_LOCK,
    input  wire [1:0]  BOOT_PINS,
    output reg         XTAL_EN,
    output reg         PLL_EN,
    output reg         SYS_CLK_OUT,
    output reg  [1:0]  SYS_SRC,
    output reg  [1:0]  BOOT_SEL,
    output reg         FLASH_SEQ_WS,
    output reg         FLASH_RAND_WS,
    output reg  [16:0] AHB_KHZ,
    output reg  [16:0] APB_KHZ,
    output reg  [16:0] USB_KHZ,
    output wire        IRQ,
    input  wire [7:0]  S_AXI_AWADDR,
    input  wire        S_AXI_AWVALID,
    output wire        S_AXI_AWREADY,
    input  wire [31:0] S_AXI_WDATA,
    input  wire [3:0]  S_AXI_WSTRB,
    input  wire        S_AXI_WVALID,
    output wire        S_AXI_WREADY,
    output reg  [1:0]  S_AXI_BRESP,
    output reg         S_AXI_BVALID,
    input  wire        S_AXI_BREADY,
    input  wire [7:0]  S_AXI_ARADDR,
    input  wire        S_AXI_ARVALID,
    output wire        S_AXI_ARREADY,
    output reg  [31:0] S_AXI_RDATA,
    output reg  [1:0]  S_AXI_RRESP,
    output reg         S_AXI_RVALID,
    input  wire        S_AXI_RREADY
);

// ==========================================================
// frequency arithmetic
// pll rates exceed 17 bits, so the arithmetic runs 20 bits wide
function [19:0] khz_of;
    input [19:0] base;
    input [5:0]  mul;
    input [3:0]  div;
    reg   [25:0] prod;
    reg   [25:0] quot;
    begin
        prod   = {6'h00, base} * ((mul == 6'h00) ? 26'h0000001 : {20'h00000, mul});
        quot   = prod / ({22'h000000, div} + 26'h0000001);
        khz_of = quot[19:0];
    end
endfunction

// ==========================================================
// synchronisers for the clock, lock and boot pin inputs
reg [4:0] s1_q, s2_q;
reg [1:0] b1_q, b2_q;
always @(posedge REF_CLK) begin
    s1_q <= {PLL_LOCK, PLL_CLK_IN, LP_CLK_IN, XTAL_CLK_IN, RC_CLK_IN};
    s2_q <= s1_q;
    b1_q <= BOOT_PINS;
    b2_q <= b1_q;
end
wire rc_s   = s2_q[0];
wire xt_s   = s2_q[1];
wire lp_s   = s2_q[2];
wire pll_s  = s2_q[3];
wire lock_s = s2_q[4];

// ==========================================================
// registers
reg  [31:0] ctrl_q, div_q;
reg  [2:0]  irq_st_q, irq_mask_q;
reg         xt_ready_q, xt_fail_q, cfg_ok_q;
wire        burst   = ctrl_q[`CCF_CTRL_BURST];
wire        slow    = ctrl_q[`CCF_CTRL_SLOW];
wire        slow_lp = ctrl_q[`CCF_CTRL_SLOW_LP];
wire [19:0] xt_khz  = ctrl_q[`CCF_CTRL_XT8] ? 20'h01F40 : 20'h00FA0;

// ==========================================================
// boot pin capture after reset release
reg [2:0] boot_cnt_q;
always @(posedge REF_CLK) begin
    if (!RST_N) begin
        boot_cnt_q <= 3'h0;
        BOOT_SEL   <= 2'h0;
    end else if ({29'h0, boot_cnt_q} != `CCF_BOOT_CYC) begin
        boot_cnt_q <= boot_cnt_q + 3'h1;
        if ({29'h0, boot_cnt_q} == `CCF_BOOT_CYC - 1)
            BOOT_SEL <= b2_q;
    end
end

// ==========================================================
// crystal enable, stabilisation and loss detection
reg        xt_prev_q;
reg [15:0] stab_q;
reg [7:0]  loss_q;
wire       xt_rise = xt_s && !xt_prev_q;
wire       osc_off = slow && slow_lp;
wire       ev_ready = XTAL_EN && !xt_ready_q && !xt_fail_q
                      && xt_rise && {16'h0, stab_q} == STAB_EDGES - 1;
wire       ev_fail  = xt_ready_q && XTAL_EN && {24'h0, loss_q} == `CCF_LOSS_CYC - 1;
always @(posedge REF_CLK) begin
    if (!RST_N || LP_EXIT) begin
        XTAL_EN    <= 1'b1;
        xt_ready_q <= 1'b0;
        xt_fail_q  <= 1'b0;
        stab_q     <= 16'h0;
        loss_q     <= 8'h0;
        xt_prev_q  <= xt_s; // no false edge if the crystal is high
    end else begin
        xt_prev_q <= xt_s;
        XTAL_EN   <= !osc_off;
        if (osc_off) begin
            xt_ready_q <= 1'b0;
            stab_q     <= 16'h0;
        end else if (!xt_ready_q && !xt_fail_q && xt_rise) begin
            stab_q <= stab_q + 16'h1;
            if (ev_ready)
                xt_ready_q <= 1'b1;
        end
        // any level change restarts the loss timer
        if (xt_s != xt_prev_q)
            loss_q <= 8'h0;
        else if (loss_q != 8'hFF)
            loss_q <= loss_q + 8'h1;
        if (ev_fail) begin
            xt_fail_q  <= 1'b1;
            xt_ready_q <= 1'b0;
        end
    end
end

// ==========================================================
// PLL enable: only with a good crystal and not in low-power slow
always @(posedge REF_CLK) begin
    if (!RST_N || LP_EXIT)
        PLL_EN <= 1'b0;
    else
        PLL_EN <= ctrl_q[`CCF_CTRL_PLL_SEL] && xt_ready_q && !osc_off;
end

// ==========================================================
// source selection with glitch-free hand-over
reg  [1:0] tgt;
reg        hold_q;
reg        cur_lvl, tgt_lvl;
always @* begin
    if (osc_off)
        tgt = `CCF_SRC_LP;
    else if (!xt_ready_q)
        tgt = `CCF_SRC_RC;
    else if (ctrl_q[`CCF_CTRL_PLL_SEL] && lock_s && cfg_ok_q)
        tgt = `CCF_SRC_PLL;
    else
        tgt = `CCF_SRC_XT;
    case (SYS_SRC)
        `CCF_SRC_RC:  cur_lvl = rc_s;
        `CCF_SRC_XT:  cur_lvl = xt_s && !xt_fail_q;
        `CCF_SRC_PLL: cur_lvl = pll_s && !xt_fail_q;
        default:      cur_lvl = lp_s;
    endcase
    case (tgt)
        `CCF_SRC_RC:  tgt_lvl = rc_s;
        `CCF_SRC_XT:  tgt_lvl = xt_s;
        `CCF_SRC_PLL: tgt_lvl = pll_s;
        default:      tgt_lvl = lp_s;
    endcase
end
// output parks low until the old phase ends and the new one is low
always @(posedge REF_CLK) begin
    if (!RST_N || LP_EXIT) begin
        SYS_SRC     <= `CCF_SRC_RC;
        hold_q      <= 1'b0;
        SYS_CLK_OUT <= 1'b0;
    end else if (!hold_q) begin
        if (tgt != SYS_SRC && !cur_lvl) begin
            hold_q      <= 1'b1;
            SYS_CLK_OUT <= 1'b0;
        end else
            SYS_CLK_OUT <= cur_lvl;
    end else begin
        SYS_CLK_OUT <= 1'b0;
        if (!tgt_lvl) begin
            SYS_SRC <= tgt;
            hold_q  <= 1'b0;
        end
    end
end

// ==========================================================
// clock tree frequencies from the divider register
wire [19:0] pll_khz = khz_of(xt_khz, div_q[5:0], 4'h0);
wire [19:0] ahb_nom = khz_of(pll_khz, 6'h1, div_q[11:8]);
wire [19:0] ahb_slw = slow ? khz_of(ahb_nom, 6'h1, div_q[23:20]) : ahb_nom;
wire [19:0] apb_nom = khz_of(ahb_slw, 6'h1, div_q[15:12]);
wire [19:0] usb_nom = khz_of(pll_khz, 6'h1, div_q[19:16]);
wire [19:0] ahb_lim = {3'h0, (ctrl_q[`CCF_CTRL_SRAM] ? `CCF_AHB_SRAM_KHZ
                    : burst ? `CCF_AHB_FLASH_KHZ : `CCF_NOBURST_KHZ)};
wire        cfg_ok  = ahb_slw <= ahb_lim && apb_nom <= {3'h0, `CCF_APB_MAX_KHZ};
always @(posedge REF_CLK) begin
    if (!RST_N) begin
        cfg_ok_q      <= 1'b0;
        AHB_KHZ       <= 17'h0;
        APB_KHZ       <= 17'h0;
        USB_KHZ       <= 17'h0;
        FLASH_SEQ_WS  <= 1'b0;
        FLASH_RAND_WS <= 1'b0;
    end else begin
        cfg_ok_q      <= cfg_ok;
        // an illegal setting is never reported while the switch is pending
        AHB_KHZ       <= (SYS_SRC == `CCF_SRC_PLL && cfg_ok) ? ahb_slw[16:0] : 17'h0;
        APB_KHZ       <= (SYS_SRC == `CCF_SRC_PLL && cfg_ok) ? apb_nom[16:0] : 17'h0;
        USB_KHZ       <= (PLL_EN && usb_nom == {3'h0, `CCF_USB_KHZ}) ? `CCF_USB_KHZ : 17'h0;
        FLASH_SEQ_WS  <= 1'b0;
        FLASH_RAND_WS <= burst;
    end
end

// ==========================================================
// AXI4-Lite write channel
reg        aw_got_q, w_got_q;
reg [7:0]  aw_q;
reg [31:0] wd_q;
reg [3:0]  ws_q;
wire       do_wr = aw_got_q && w_got_q && !S_AXI_BVALID;
assign S_AXI_AWREADY = !aw_got_q && !S_AXI_BVALID;
assign S_AXI_WREADY  = !w_got_q && !S_AXI_BVALID;
function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  st;
    integer i;
    begin
        merge = old;
        for (i = 0; i < 4; i = i + 1)
            if (st[i])
                merge[i*8 +: 8] = nw[i*8 +: 8];
    end
endfunction
wire       mapped_w = aw_q == `CCF_REG_CTRL || aw_q == `CCF_REG_DIV
                   || aw_q == `CCF_REG_STAT || aw_q == `CCF_REG_IRQ_STAT
                   || aw_q == `CCF_REG_IRQ_MASK;
wire [31:0] div_new = merge(div_q, wd_q, ws_q);
wire        ev_rej  = do_wr && aw_q == `CCF_REG_DIV && !cfg_ok_q && div_new != div_q;
wire [2:0]  w1c     = (do_wr && aw_q == `CCF_REG_IRQ_STAT && ws_q[0]) ? wd_q[2:0] : 3'h0;
always @(posedge REF_CLK) begin
    if (!RST_N) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        aw_q         <= 8'h0;
        wd_q         <= 32'h0;
        ws_q         <= 4'h0;
        S_AXI_BVALID <= 1'b0;
        S_AXI_BRESP  <= 2'h0;
        ctrl_q       <= `CCF_CTRL_RST;
        div_q        <= `CCF_DIV_RST;
        irq_mask_q   <= 3'h0;
    end else begin
        if (S_AXI_AWVALID && S_AXI_AWREADY) begin
            aw_got_q <= 1'b1;
            aw_q     <= {S_AXI_AWADDR[7:2], 2'b00};
        end
        if (S_AXI_WVALID && S_AXI_WREADY) begin
            w_got_q <= 1'b1;
            wd_q    <= S_AXI_WDATA;
            ws_q    <= S_AXI_WSTRB;
        end
        if (do_wr) begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            S_AXI_BVALID <= 1'b1;
            S_AXI_BRESP  <= mapped_w ? 2'b00 : 2'b10;
            if (aw_q == `CCF_REG_CTRL)
                ctrl_q <= merge(ctrl_q, wd_q, ws_q) & 32'h0000_003F;
            if (aw_q == `CCF_REG_DIV)
                div_q <= div_new & 32'h00FF_FF3F;
            if (aw_q == `CCF_REG_IRQ_MASK && ws_q[0])
                irq_mask_q <= wd_q[2:0];
        end else if (S_AXI_BVALID && S_AXI_BREADY)
            S_AXI_BVALID <= 1'b0;
    end
end

// ==========================================================
// sticky interrupt status, set wins over clear
always @(posedge REF_CLK) begin
    if (!RST_N)
        irq_st_q <= 3'h0;
    else
        irq_st_q <= (irq_st_q & ~w1c) | {ev_rej, ev_ready, ev_fail};
end
assign IRQ = |(irq_st_q & irq_mask_q);

// ==========================================================
// AXI4-Lite read channel, one cycle answer
assign S_AXI_ARREADY = !S_AXI_RVALID;
wire [31:0] stat_w = {20'h0, BOOT_SEL, 3'h0, cfg_ok_q,
                      lock_s, xt_fail_q, xt_ready_q, hold_q, SYS_SRC};
always @(posedge REF_CLK) begin
    if (!RST_N) begin
        S_AXI_RVALID <= 1'b0;
        S_AXI_RDATA  <= 32'h0;
        S_AXI_RRESP  <= 2'h0;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= 2'b00;
        case ({S_AXI_ARADDR[7:2], 2'b00})
            `CCF_REG_CTRL:     S_AXI_RDATA <= ctrl_q;
            `CCF_REG_DIV:      S_AXI_RDATA <= div_q;
            `CCF_REG_STAT:     S_AXI_RDATA <= stat_w;
            `CCF_REG_IRQ_STAT: S_AXI_RDATA <= {29'h0, irq_st_q};
            `CCF_REG_IRQ_MASK: S_AXI_RDATA <= {29'h0, irq_mask_q};
            default: begin
                S_AXI_RDATA <= 32'h0;
                S_AXI_RRESP <= 2'b10;
            end
        endcase
    end else if (S_AXI_RVALID && S_AXI_RREADY)
        S_AXI_RVALID <= 1'b0;
end

endmodule

// ### dv/ccf_xtal_model.sv
// behavioural crystal oscillator at the far side of the controller
// assumes the enable comes from the controller and stop from the bench
`timescale 1ns/10ps
module ccf_xtal_model #(
    parameter HALF_NS = 125
) (
    input  wire en,
    input  wire stop,
    output reg  clk
);
    // ==========================================================
    // oscillation, held low while disabled or broken
    initial clk = 1'b0;
    always begin
        #HALF_NS;
        clk = (en && !stop) ? ~clk : 1'b0;
    end
endmodule

// ### dv/ccf_clock_ctrl_monitor.sv
// assertion checker for the clock start-up and failover controller
// assumes it is bound to ccf_clock_ctrl and sees its ports only
`timescale 1ns/10ps
`include "ccf_defines.vh"
module ccf_clock_ctrl_monitor (
    input wire        REF_CLK,
    input wire        RST_N,
    input wire        LP_EXIT,
    input wire        XTAL_CLK_IN,
    input wire [1:0]  BOOT_PINS,
    input wire        XTAL_EN,
    input wire        PLL_EN,
    input wire        SYS_CLK_OUT,
    input wire [1:0]  SYS_SRC,
    input wire [1:0]  BOOT_SEL,
    input wire [16:0] APB_KHZ,
    input wire [16:0] USB_KHZ
);
    // ==========================================================
    // cycles the crystal input has stood still
    reg [7:0] still_q;
    reg       last_q;
    always @(posedge REF_CLK) begin
        last_q <= XTAL_CLK_IN;
        if (!RST_N || XTAL_CLK_IN != last_q) begin
            still_q <= 8'h00;
        end else if (still_q != 8'hFF) begin
            still_q <= still_q + 8'h01;
        end
    end
    // ==========================================================
    // properties
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);
    property p_rc_start;
        ($rose(RST_N) || LP_EXIT) |-> ##[0:3] (SYS_SRC == `CCF_SRC_RC);
    endproperty
    a_rc_start: assert property (p_rc_start) else $error("no rc start");
    property p_xt_on;
        ($rose(RST_N) || $past(LP_EXIT)) |-> XTAL_EN;
    endproperty
    a_xt_on: assert property (p_xt_on) else $error("crystal not enabled");
    property p_loss;
        (still_q > 8'h3C) |-> (SYS_SRC != `CCF_SRC_XT && SYS_SRC != `CCF_SRC_PLL);
    endproperty
    a_loss: assert property (p_loss) else $error("dead crystal still used");
    property p_apb;
        APB_KHZ <= `CCF_APB_MAX_KHZ;
    endproperty
    a_apb: assert property (p_apb) else $error("apb too fast");
    property p_usb;
        (USB_KHZ != 17'h00000) |-> (USB_KHZ == `CCF_USB_KHZ && (PLL_EN || $past(PLL_EN)));
    endproperty
    a_usb: assert property (p_usb) else $error("usb clock wrong");
    property p_boot;
        $rose(RST_N) |-> ##6 (BOOT_SEL == BOOT_PINS);
    endproperty
    a_boot: assert property (p_boot) else $error("boot pins lost");
    property p_lp;
        (SYS_SRC == `CCF_SRC_LP) |-> !PLL_EN;
    endproperty
    a_lp: assert property (p_lp) else $error("pll on in lp");
    property p_glitch;
        ($changed(SYS_SRC) && !$past(LP_EXIT)) |-> !SYS_CLK_OUT;
    endproperty
    a_glitch: assert property (p_glitch) else $error("switch while high");
endmodule
bind ccf_clock_ctrl ccf_clock_ctrl_monitor u_mon (.REF_CLK(REF_CLK), .RST_N(RST_N),
    .LP_EXIT(LP_EXIT), .XTAL_CLK_IN(XTAL_CLK_IN), .BOOT_PINS(BOOT_PINS), .XTAL_EN(XTAL_EN),
    .PLL_EN(PLL_EN), .SYS_CLK_OUT(SYS_CLK_OUT), .SYS_SRC(SYS_SRC), .BOOT_SEL(BOOT_SEL),
    .APB_KHZ(APB_KHZ), .USB_KHZ(USB_KHZ));

// ### dv/ccf_clock_ctrl_tb.sv
// self-checking bench for the clock start-up and failover controller
// assumes the crystal model and the bound checker are compiled alongside
`timescale 1ns/10ps
`include "ccf_defines.vh"
module ccf_clock_ctrl_tb;
    reg         REF_CLK = 1'b0, RST_N = 1'b0, LP_EXIT = 1'b0, PLL_LOCK = 1'b0, xt_stop = 1'b0;
    reg         RC_CLK_IN = 1'b0, LP_CLK_IN = 1'b0, PLL_CLK_IN = 1'b0;
    reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    reg  [1:0]  BOOT_PINS = 2'h2, resp;
    reg  [7:0]  awaddr = 8'h00, araddr = 8'h00;
    reg  [31:0] wdata = 32'h0, rdat;
    wire        xt, XTAL_EN, PLL_EN, SYS_CLK_OUT, IRQ, awready, wready, bvalid;
    wire        arready, rvalid, seq_ws, rand_ws;
    wire [1:0]  SYS_SRC, BOOT_SEL, bresp, rresp;
    wire [16:0] AHB_KHZ, APB_KHZ, USB_KHZ;
    wire [31:0] rdata;
    integer     err_count = 0, comparisons = 0;
    // ==========================================================
    // clocks, sources slowed so the synchronisers see every phase
    always #50 REF_CLK = ~REF_CLK;
    always #230 RC_CLK_IN = ~RC_CLK_IN;
    always #170 PLL_CLK_IN = ~PLL_CLK_IN;
    always #1700 LP_CLK_IN = ~LP_CLK_IN;
    ccf_xtal_model #(.HALF_NS(250)) u_xtal (.en(XTAL_EN), .stop(xt_stop), .clk(xt));
    ccf_clock_ctrl #(.STAB_EDGES(8)) uut (.REF_CLK(REF_CLK), .RST_N(RST_N), .LP_EXIT(LP_EXIT),
        .RC_CLK_IN(RC_CLK_IN), .XTAL_CLK_IN(xt), .LP_CLK_IN(LP_CLK_IN), .PLL_CLK_IN(PLL_CLK_IN),
        .PLL_LOCK(PLL_LOCK), .BOOT_PINS(BOOT_PINS), .XTAL_EN(XTAL_EN), .PLL_EN(PLL_EN),
        .SYS_CLK_OUT(SYS_CLK_OUT), .SYS_SRC(SYS_SRC), .BOOT_SEL(BOOT_SEL), .FLASH_SEQ_WS(seq_ws),
        .FLASH_RAND_WS(rand_ws), .AHB_KHZ(AHB_KHZ), .APB_KHZ(APB_KHZ), .USB_KHZ(USB_KHZ),
        .IRQ(IRQ), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
        .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
        .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
        .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
        .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
    // ==========================================================
    // reporting and bus tasks
    task final_report;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, err_count);
            if (err_count == 0 && comparisons > 0) begin
                $display("bench passed");
            end else begin
                $display("bench failed");
            end
            $finish;
        end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (got !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask
    task tmo;
        begin
            err_count = err_count + 1;
            $display("[ERR] %0t wait ran out", $time);
            final_report;
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        reg ta, tw, bv;
        integer n;
        begin
            @(posedge REF_CLK);
            awaddr <= a;
            wdata <= d;
            awvalid <= 1'b1;
            wvalid <= 1'b1;
            bready <= 1'b1;
            bv = 1'b0;
            for (n = 0; n < 50 && !bv; n = n + 1) begin
                @(negedge REF_CLK);
                ta = awvalid && awready;
                tw = wvalid && wready;
                bv = bvalid;
                resp = bresp;
                @(posedge REF_CLK);
                if (ta) awvalid <= 1'b0;
                if (tw) wvalid <= 1'b0;
            end
            bready <= 1'b0;
            if (!bv) tmo;
            @(negedge REF_CLK);
        end
    endtask
    task rd(input [7:0] a);
        reg ta, rv;
        integer n;
        begin
            @(posedge REF_CLK);
            araddr <= a;
            arvalid <= 1'b1;
            rready <= 1'b1;
            rv = 1'b0;
            for (n = 0; n < 50 && !rv; n = n + 1) begin
                @(negedge REF_CLK);
                ta = arvalid && arready;
                rv = rvalid;
                rdat = rdata;
                resp = rresp;
                @(posedge REF_CLK);
                if (ta) arvalid <= 1'b0;
            end
            rready <= 1'b0;
            if (!rv) tmo;
            @(negedge REF_CLK);
        end
    endtask
    task wait_src(input [1:0] s);
        integer n;
        begin
            @(negedge REF_CLK);
            for (n = 0; n < 3000 && SYS_SRC !== s; n = n + 1) @(negedge REF_CLK);
            if (SYS_SRC !== s) tmo;
        end
    endtask
    // ==========================================================
    // test sequence
    initial begin
        repeat (20) @(posedge REF_CLK);
        RST_N <= 1'b1;
        @(negedge REF_CLK);
        chk(SYS_SRC, `CCF_SRC_RC);
        chk(XTAL_EN, 1'b1);
        repeat (6) @(negedge REF_CLK);
        chk(BOOT_SEL, 2'h2);
        rd(`CCF_REG_DIV);
        chk(rdat, `CCF_DIV_RST);
        rd(8'h20);
        chk(resp, 2'h2);
        wr(8'h20, 32'h0000_0001);
        chk(resp, 2'h2);
        $display("test reset done");
        // ready interrupt raised, masked, cleared
        wr(`CCF_REG_IRQ_MASK, 32'h2);
        chk(resp, 2'h0);
        wait_src(`CCF_SRC_XT);
        chk(IRQ, 1'b1);
        wr(`CCF_REG_IRQ_MASK, 32'h0);
        chk(IRQ, 1'b0);
        wr(`CCF_REG_IRQ_MASK, 32'h2);
        wr(`CCF_REG_IRQ_STAT, 32'h2);
        chk(IRQ, 1'b0);
        $display("test irq done");
        // 240 MHz pll: ahb 60, usb 48, apb 30
        @(posedge REF_CLK) PLL_LOCK <= 1'b1;
        wr(`CCF_REG_DIV, 32'h0004_133C);
        wr(`CCF_REG_CTRL, 32'h09);
        wait_src(`CCF_SRC_PLL);
        rd(`CCF_REG_STAT);
        chk(rdat[6], 1'b1);
        chk(AHB_KHZ, `CCF_AHB_FLASH_KHZ);
        chk(USB_KHZ, `CCF_USB_KHZ);
        chk(APB_KHZ, 17'h07530);
        chk({seq_ws, rand_ws}, 2'h1);
        // no burst: 60 MHz refused
        wr(`CCF_REG_CTRL, 32'h01);
        wr(`CCF_REG_DIV, 32'h0004_233C);
        wait_src(`CCF_SRC_XT);
        rd(`CCF_REG_IRQ_STAT);
        chk(rdat[2], 1'b1);
        // sram fetch at 64 MHz from an 8 MHz crystal, then slow modes
        wr(`CCF_REG_DIV, 32'h0000_7110);
        wr(`CCF_REG_CTRL, 32'h07);
        wait_src(`CCF_SRC_PLL);
        rd(`CCF_REG_STAT);
        chk(AHB_KHZ, `CCF_AHB_SRAM_KHZ);
        wr(`CCF_REG_DIV, 32'h0030_7110);
        wr(`CCF_REG_CTRL, 32'h17);
        rd(`CCF_REG_STAT);
        chk(AHB_KHZ != 17'h0 && AHB_KHZ < `CCF_AHB_SRAM_KHZ, 1'b1);
        wr(`CCF_REG_CTRL, 32'h37);
        wait_src(`CCF_SRC_LP);
        chk({PLL_EN, XTAL_EN}, 2'h0);
        $display("test tree done");
        // crystal loss falls back to rc
        wr(`CCF_REG_CTRL, 32'h00);
        wait_src(`CCF_SRC_XT);
        wr(`CCF_REG_IRQ_MASK, 32'h1);
        xt_stop <= 1'b1;
        wait_src(`CCF_SRC_RC);
        rd(`CCF_REG_IRQ_STAT);
        chk(rdat[0], 1'b1);
        chk(IRQ, 1'b1);
        // low-power exit restarts the crystal
        xt_stop <= 1'b0;
        @(posedge REF_CLK);
        LP_EXIT <= 1'b1;
        @(posedge REF_CLK);
        LP_EXIT <= 1'b0;
        @(negedge REF_CLK);
        chk({SYS_SRC, XTAL_EN}, 3'h1);
        wait_src(`CCF_SRC_XT);
        // exit while running on the crystal drops back to rc at once
        @(posedge REF_CLK);
        LP_EXIT <= 1'b1;
        @(posedge REF_CLK);
        LP_EXIT <= 1'b0;
        @(negedge REF_CLK);
        chk({SYS_SRC, XTAL_EN}, 3'h1);
        wait_src(`CCF_SRC_XT);
        $display("test failover done");
        final_report;
    end
endmodule
